/* File: core/gpjk_axil_slave.sv */
// AXI4-Lite slave front end for the port J/K control block
`timescale 1ns/1ps
module gpjk_axil_slave
    import gpjk_pkg::*;
#(
    parameter int ADDR_W = GPJK_ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   wrEn,
    output logic [ADDR_W-1:0]      wrAddr,
    output logic [31:0]            wrData,
    output logic [3:0]             wrStrb,
    input  wire logic              wrHit,
    output logic [ADDR_W-1:0]      rdAddr,
    input  wire logic [31:0]       rdData,
    input  wire logic              rdHit
);
    typedef struct packed {
        logic              awHave;
        logic              wHave;
        logic              awReady;
        logic              wReady;
        logic [ADDR_W-1:0] awAddr;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              bValid;
        logic [1:0]        bResp;
        gpjk_rd_e          rdState;
        logic              arReady;
        logic [ADDR_W-1:0] arAddr;
        logic              rValid;
        logic [31:0]       rData;
        logic [1:0]        rResp;
    } gpjk_axs_s;

    gpjk_axs_s st_r;
    gpjk_axs_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        wrEn   = st_r.awHave && st_r.wHave && !st_r.bValid;
        if (awvalid && st_r.awReady) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = awaddr;
        end
        if (wvalid && st_r.wReady) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = wdata;
            st_nxt.wStrb = wstrb;
        end
        // Address and data may arrive in either order; the write fires once both are held
        if (wrEn) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = wrHit ? GPJK_RESP_OKAY : GPJK_RESP_SLVERR;
        end
        if (st_r.bValid && bready) begin
            st_nxt.bValid = 1'b0;
        end
        case (st_r.rdState)
            GPJK_RD_IDLE: begin
                if (arvalid) begin
                    st_nxt.arAddr  = araddr;
                    st_nxt.rdState = GPJK_RD_FETCH;
                end
            end
            GPJK_RD_FETCH: begin
                // Unmapped reads answer zero with an error
                st_nxt.rData   = rdHit ? rdData : 32'h0000_0000;
                st_nxt.rResp   = rdHit ? GPJK_RESP_OKAY : GPJK_RESP_SLVERR;
                st_nxt.rValid  = 1'b1;
                st_nxt.rdState = GPJK_RD_RESP;
            end
            GPJK_RD_RESP: begin
                if (rready) begin
                    st_nxt.rValid  = 1'b0;
                    st_nxt.rdState = GPJK_RD_IDLE;
                end
            end
            default: begin
                st_nxt.rValid  = 1'b0;
                st_nxt.rdState = GPJK_RD_IDLE;
            end
        endcase
        // Ready lowers while a transfer is pending, so one write and one read at a time
        st_nxt.awReady = !st_nxt.awHave && !st_nxt.bValid;
        st_nxt.wReady  = !st_nxt.wHave && !st_nxt.bValid;
        st_nxt.arReady = st_nxt.rdState == GPJK_RD_IDLE;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r         <= '0;
            st_r.rdState <= GPJK_RD_IDLE;
            st_r.awReady <= 1'b1;
            st_r.wReady  <= 1'b1;
            st_r.arReady <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.awReady;
    assign wready  = st_r.wReady;
    assign bvalid  = st_r.bValid;
    assign bresp   = st_r.bResp;
    assign arready = st_r.arReady;
    assign rvalid  = st_r.rValid;
    assign rdata   = st_r.rData;
    assign rresp   = st_r.rResp;
    assign wrAddr  = st_r.awAddr;
    assign wrData  = st_r.wData;
    assign wrStrb  = st_r.wStrb;
    assign rdAddr  = st_r.arAddr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence readTaken;
        arvalid && arready;
    endsequence

    readAnswer_timing_a: assert property (readTaken |=> !rvalid ##1 rvalid) // R18
        else $error("read answer not two cycles after address");
    errorData_zero_a: assert property (rvalid && rresp == GPJK_RESP_SLVERR |-> rdata == 32'h0000_0000) // R18
        else $error("unmapped read returned nonzero data");
endmodule // gpjk_axil_slave

/* File: core/gpjk_port_ctrl.sv */
// Port J/K pin control: register file, pin muxing and irq gating
`timescale 1ns/1ps
module gpjk_port_ctrl
    import gpjk_pkg::*;
#(
    parameter int ADDR_W = GPJK_ADDR_W,
    parameter int K_PINS = GPJK_K_PINS,
    parameter int J_PINS = GPJK_J_PINS
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [K_PINS-1:0] smallPinIn,
    output logic [K_PINS-1:0]      smallPinOut,
    output logic [K_PINS-1:0]      smallPinOe,
    output logic [K_PINS-1:0]      smallPullupEn,
    output logic [K_PINS-1:0]      smallInBufEn,
    input  wire logic              timerNineOutput,
    input  wire logic              systemClockOutput,
    input  wire logic              alarmOutput,
    output logic                   cecInput,
    input  wire logic [J_PINS-1:0] widePinIn,
    input  wire logic              timerSixOutput,
    input  wire logic              timerSevenOutput,
    input  wire logic              stopMode,
    output logic [1:0]             wideTimerOut,
    output logic [1:0]             wideTimerOe,
    output logic [J_PINS-1:0]      widePullupEn,
    output logic [J_PINS-1:0]      wideInBufEn,
    output logic [5:0]             extIrqLines
);
    typedef struct packed {
        logic [K_PINS-1:0] smallPinData;
        logic [K_PINS-1:0] smallOutputEnable;
        logic [K_PINS-1:0] smallFunction1;
        logic              pin1AlarmOutputSelect;
        logic [K_PINS-1:0] smallPullup;
        logic [K_PINS-1:0] smallInputEnable;
        logic [J_PINS-1:0] wideFunction;
        logic [J_PINS-1:0] widePullup;
        logic [J_PINS-1:0] wideInputEnable;
        logic [K_PINS-1:0] pinOut;
        logic [K_PINS-1:0] pinOe;
        logic [K_PINS-1:0] pullupOut;
        logic [K_PINS-1:0] inBufOut;
        logic              cec;
        logic [1:0]        wTimerOut;
        logic [1:0]        wTimerOe;
        logic [J_PINS-1:0] wPullupOut;
        logic [J_PINS-1:0] wInBufOut;
        logic [5:0]        irqOut;
    } gpjk_port_s;

    gpjk_port_s        st_r;
    gpjk_port_s        st_nxt;
    logic              wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [31:0]       wrData;
    logic [3:0]        wrStrb;
    logic [ADDR_W-1:0] rdAddr;
    logic [31:0]       rdData;
    logic              wrHit;
    logic              rdHit;
    logic [J_PINS-1:0] wideIrqPass;
    logic [5:0]        irqPins;
    logic [5:0]        irqGate;

    // Word index match; byte offsets within a word are ignored
    function automatic logic atOffset(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        atOffset = a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = atOffset(a, GPJK_K_DATA_OFF) || atOffset(a, GPJK_K_OE_OFF) ||
                   atOffset(a, GPJK_K_FN1_OFF) || atOffset(a, GPJK_K_FN2_OFF) ||
                   atOffset(a, GPJK_K_PUP_OFF) || atOffset(a, GPJK_K_IE_OFF) ||
                   atOffset(a, GPJK_J_FN_OFF) || atOffset(a, GPJK_J_PUP_OFF) ||
                   atOffset(a, GPJK_J_IE_OFF);
    endfunction

    gpjk_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk     (clk),
        .resetn  (resetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrHit   (wrHit),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .rdHit   (rdHit)
    );

    assign wrHit = isMapped(wrAddr);
    assign rdHit = isMapped(rdAddr);

    // Readback; only implemented bits reach the bus, the rest stay zero
    always_comb begin
        rdData = 32'h0000_0000; // R18
        if (atOffset(rdAddr, GPJK_K_DATA_OFF)) begin
            // Driven pins read the latch, others read the pin through its input buffer
            rdData[K_PINS-1:0] = (st_r.smallOutputEnable & st_r.smallPinData) |
                                 (~st_r.smallOutputEnable & st_r.smallInputEnable & smallPinIn); // R4
        end else if (atOffset(rdAddr, GPJK_K_OE_OFF)) begin
            rdData[K_PINS-1:0] = st_r.smallOutputEnable; // R5
        end else if (atOffset(rdAddr, GPJK_K_FN1_OFF)) begin
            rdData[K_PINS-1:0] = st_r.smallFunction1; // R6
        end else if (atOffset(rdAddr, GPJK_K_FN2_OFF)) begin
            rdData[GPJK_K_ALARM_BIT] = st_r.pin1AlarmOutputSelect; // R15
        end else if (atOffset(rdAddr, GPJK_K_PUP_OFF)) begin
            rdData[K_PINS-1:0] = st_r.smallPullup; // R16
        end else if (atOffset(rdAddr, GPJK_K_IE_OFF)) begin
            rdData[K_PINS-1:0] = st_r.smallInputEnable; // R9
        end else if (atOffset(rdAddr, GPJK_J_FN_OFF)) begin
            rdData[J_PINS-1:0] = st_r.wideFunction; // R10
        end else if (atOffset(rdAddr, GPJK_J_PUP_OFF)) begin
            rdData[J_PINS-1:0] = st_r.widePullup; // R11
        end else if (atOffset(rdAddr, GPJK_J_IE_OFF)) begin
            rdData[J_PINS-1:0] = st_r.wideInputEnable; // R12
        end
    end

    // In stop mode only pins with both function and input selected may wake the chip
    assign wideIrqPass = stopMode ? (st_r.wideFunction & st_r.wideInputEnable) : st_r.wideInputEnable; // R14 R13
    assign irqPins     = {widePinIn[7:6], widePinIn[3:0]};
    assign irqGate     = {wideIrqPass[7:6], wideIrqPass[3:0]};

    always_comb begin
        st_nxt = st_r;
        if (wrEn && wrStrb[0]) begin
            if (atOffset(wrAddr, GPJK_K_DATA_OFF)) begin
                st_nxt.smallPinData = wrData[K_PINS-1:0]; // R4
            end
            if (atOffset(wrAddr, GPJK_K_OE_OFF)) begin
                st_nxt.smallOutputEnable = wrData[K_PINS-1:0]; // R5 R1
            end
            if (atOffset(wrAddr, GPJK_K_FN1_OFF)) begin
                st_nxt.smallFunction1 = wrData[K_PINS-1:0]; // R6
            end
            if (atOffset(wrAddr, GPJK_K_FN2_OFF)) begin
                st_nxt.pin1AlarmOutputSelect = wrData[GPJK_K_ALARM_BIT]; // R7 R15
            end
            if (atOffset(wrAddr, GPJK_K_PUP_OFF)) begin
                // Open-drain pin has no pull-up, so its bit is not stored
                st_nxt.smallPullup = {wrData[K_PINS-1:1], 1'b0}; // R8 R16 R18
            end
            if (atOffset(wrAddr, GPJK_K_IE_OFF)) begin
                st_nxt.smallInputEnable = wrData[K_PINS-1:0]; // R9
            end
            if (atOffset(wrAddr, GPJK_J_FN_OFF)) begin
                st_nxt.wideFunction = wrData[J_PINS-1:0]; // R10
            end
            if (atOffset(wrAddr, GPJK_J_PUP_OFF)) begin
                st_nxt.widePullup = wrData[J_PINS-1:0]; // R11
            end
            if (atOffset(wrAddr, GPJK_J_IE_OFF)) begin
                st_nxt.wideInputEnable = wrData[J_PINS-1:0]; // R12
            end
        end

        // Pin 0 only ever sinks; a one releases the line to the external pull-up
        st_nxt.pinOut[0] = 1'b0; // R3
        st_nxt.pinOe[0]  = st_r.smallOutputEnable[0] && !st_r.smallPinData[0]; // R3
        // Clock output takes precedence over alarm when software sets both
        st_nxt.pinOut[1] = st_r.smallFunction1[1] ? systemClockOutput :
                           st_r.pin1AlarmOutputSelect ? alarmOutput : st_r.smallPinData[1]; // R17 R15
        st_nxt.pinOe[1]  = st_r.smallOutputEnable[1]; // R5
        st_nxt.pinOut[2] = st_r.smallFunction1[2] ? timerNineOutput : st_r.smallPinData[2]; // R17 R6
        st_nxt.pinOe[2]  = st_r.smallOutputEnable[2]; // R5
        st_nxt.pullupOut = st_r.smallPullup; // R16
        st_nxt.inBufOut  = st_r.smallInputEnable; // R9
        st_nxt.cec       = st_r.smallFunction1[0] && st_r.smallInputEnable[0] && smallPinIn[0]; // R6

        st_nxt.wTimerOut  = {timerSevenOutput, timerSixOutput} & st_r.wideFunction[5:4]; // R10
        st_nxt.wTimerOe   = st_r.wideFunction[5:4]; // R10
        st_nxt.wPullupOut = st_r.widePullup; // R11
        st_nxt.wInBufOut  = st_r.wideInputEnable; // R12
        st_nxt.irqOut     = irqPins & irqGate; // R14
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0; // R2
        end else begin
            st_r <= st_nxt;
        end
    end

    assign smallPinOut   = st_r.pinOut;
    assign smallPinOe    = st_r.pinOe;
    assign smallPullupEn = st_r.pullupOut;
    assign smallInBufEn  = st_r.inBufOut;
    assign cecInput      = st_r.cec;
    assign wideTimerOut  = st_r.wTimerOut;
    assign wideTimerOe   = st_r.wTimerOe;
    assign widePullupEn  = st_r.wPullupOut;
    assign wideInBufEn   = st_r.wInBufOut;
    assign extIrqLines   = st_r.irqOut;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence regWrite(logic [7:0] off);
        wrEn && wrStrb[0] && atOffset(wrAddr, off);
    endsequence

    openDrain_sink_a: assert property (st_r.smallOutputEnable[0] && !st_r.smallPinData[0] |=> smallPinOe[0] && !smallPinOut[0]) // R3
        else $error("open drain pin not sinking");
    openDrain_release_a: assert property (st_r.smallPinData[0] |=> !smallPinOe[0]) // R3
        else $error("open drain pin not released");
    outEnable_off_a: assert property (st_r.smallOutputEnable[2:1] == 2'h0 |=> smallPinOe[2:1] == 2'h0) // R5
        else $error("driver on while output disabled");
    timerRoute_pin2_a: assert property (st_r.smallFunction1[2] |=> smallPinOut[2] == $past(timerNineOutput)) // R17
        else $error("pin 2 not following timer");
    clockRoute_pin1_a: assert property (st_r.smallFunction1[1] |=> smallPinOut[1] == $past(systemClockOutput)) // R17
        else $error("pin 1 not following clock output");
    alarmSel_write_a: assert property (regWrite(GPJK_K_FN2_OFF) |=> st_r.pin1AlarmOutputSelect == $past(wrData[1])) // R15
        else $error("alarm select not stored");
    pullupBit0_zero_a: assert property (regWrite(GPJK_K_PUP_OFF) |=> st_r.smallPullup[0] == 1'b0 ##1 !smallPullupEn[0]) // R16
        else $error("pull-up bit 0 set");
    widePullup_write_a: assert property (regWrite(GPJK_J_PUP_OFF) |=> st_r.widePullup == $past(wrData[7:0])) // R11
        else $error("wide pull-up not stored");
    irqPass_awake_a: assert property (!stopMode && st_r.wideInputEnable[1] && widePinIn[1] |=> extIrqLines[1]) // R14
        else $error("irq not passed with input enabled");
    irqBlock_stop_a: assert property (stopMode && !st_r.wideFunction[6] |=> !extIrqLines[4]) // R14
        else $error("irq passed in stop without function");
    wideTimer_route_a: assert property (st_r.wideFunction[4] |=> wideTimerOe[0] && wideTimerOut[0] == $past(timerSixOutput)) // R10
        else $error("wide timer output not routed");
endmodule // gpjk_port_ctrl

/* File: inc/gpjk_pkg.sv */
// Constants, register map and types for the port J/K control block
// What this block does
// R1: Small port has three pins, direction set per pin.
// R2: Reset leaves small port pins plain GPIO, input, output, pull-up off.
// R3: Small port pin 0 is open drain: pulls low, never drives high.
// R4: Small port data register at 0x00, data in bits 2-0, rest zero.
// R5: Output enable register at 0x04, one driver enable per pin in bits 2-0.
// R6: First function register at 0x08: bit2 timer, bit1 clock out, bit0 CEC.
// R7: Second function register at 0x0C selects further alternate functions.
// R8: Small port pull-up register at 0x2C enables pin pull-ups.
// R9: Small port input register at 0x38 enables pin input buffers.
// R10: Wide port function bits 7,6,3-0 pick irq inputs; bits 5,4 timer outputs.
// R11: Wide port pull-up register bits 7-0 read/write, bits 31-8 read zero.
// R12: Wide port input register bits 7-0 enable input buffers, reset zero.
// R13: Software waking from stop selects irq function and enables input.
// R14: Outside stop mode, input enable alone passes the pin to its irq.
// R15: Second function bit 1 routes pin 1 to alarm; other bits read zero.
// R16: Small port pull-up exists only in bits 2-1; bit 0 reads zero.
// R17: A selected peripheral output drives the pin instead of the data register.
// R18: Reserved bits ignore writes and read as zero.
package gpjk_pkg;
    localparam int         GPJK_ADDR_W      = 8;
    localparam int         GPJK_K_PINS      = 3;
    localparam int         GPJK_J_PINS      = 8;
    localparam logic [7:0] GPJK_K_DATA_OFF  = 8'h00;
    localparam logic [7:0] GPJK_K_OE_OFF    = 8'h04;
    localparam logic [7:0] GPJK_K_FN1_OFF   = 8'h08;
    localparam logic [7:0] GPJK_K_FN2_OFF   = 8'h0c;
    localparam logic [7:0] GPJK_K_PUP_OFF   = 8'h2c;
    localparam logic [7:0] GPJK_K_IE_OFF    = 8'h38;
    localparam logic [7:0] GPJK_J_FN_OFF    = 8'h40;
    localparam logic [7:0] GPJK_J_PUP_OFF   = 8'h44;
    localparam logic [7:0] GPJK_J_IE_OFF    = 8'h48;
    localparam int         GPJK_K_ALARM_BIT = 1;
    localparam logic [1:0] GPJK_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPJK_RESP_SLVERR = 2'h2;
    localparam logic [2:0] GPJK_K_RESET     = 3'h0;
    localparam logic [7:0] GPJK_J_RESET     = 8'h00;

    typedef enum logic [2:0] {
        GPJK_RD_IDLE  = 3'b001,
        GPJK_RD_FETCH = 3'b010,
        GPJK_RD_RESP  = 3'b100
    } gpjk_rd_e;
endpackage

/* File: tb/gpjk_pin_model.sv */
// Pin side of the small port: drivers, pull-ups and external sources
`timescale 1ns/1ps
module gpjk_pin_model
    import gpjk_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [2:0] smallPinOut,
    input  wire logic [2:0] smallPinOe,
    input  wire logic [2:0] smallPullupEn,
    input  wire logic [2:0] extLevel,
    input  wire logic [2:0] extEn,
    output logic [2:0]      smallPinIn
);
    // Floating pins wander so a stale value never passes by luck
    logic [2:0] floatPat_r = 3'h5;
    always_ff @(posedge clk) begin
        floatPat_r <= ~floatPat_r;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (smallPinOe[i]) begin
                smallPinIn[i] = smallPinOut[i];
            end else if (extEn[i]) begin
                smallPinIn[i] = extLevel[i];
            end else if (smallPullupEn[i]) begin
                smallPinIn[i] = 1'b1;
            end else begin
                smallPinIn[i] = floatPat_r[i];
            end
        end
    end
endmodule // gpjk_pin_model

/* File: tb/gpjk_port_ctrl_tb.sv */
// Register-level testbench for the port J/K control block
`timescale 1ns/1ps
module gpjk_port_ctrl_tb
    import gpjk_pkg::*;
;
    logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, widePinIn, widePullupEn, wideInBufEn;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, wideTimerOut, wideTimerOe;
    logic [2:0] smallPinIn, smallPinOut, smallPinOe, smallPullupEn, smallInBufEn, extLevel, extEn;
    logic timerNine, sysClkOut, alarm, cecInput, timerSix, timerSeven, stopMode;
    logic [5:0] extIrqLines;
    int bad_count = 0;
    int num_checks = 0;

    gpjk_port_ctrl i_gpjk_port_ctrl (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .smallPinIn(smallPinIn),
        .smallPinOut(smallPinOut), .smallPinOe(smallPinOe), .smallPullupEn(smallPullupEn),
        .smallInBufEn(smallInBufEn), .timerNineOutput(timerNine), .systemClockOutput(sysClkOut),
        .alarmOutput(alarm), .cecInput(cecInput), .widePinIn(widePinIn), .timerSixOutput(timerSix),
        .timerSevenOutput(timerSeven), .stopMode(stopMode), .wideTimerOut(wideTimerOut),
        .wideTimerOe(wideTimerOe), .widePullupEn(widePullupEn), .wideInBufEn(wideInBufEn),
        .extIrqLines(extIrqLines));
    gpjk_pin_model i_gpjk_pin_model (.clk(clk), .smallPinOut(smallPinOut), .smallPinOe(smallPinOe),
        .smallPullupEn(smallPullupEn), .extLevel(extLevel), .extEn(extEn), .smallPinIn(smallPinIn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Mismatches %0d, checks %0d", bad_count, num_checks);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Handshakes are sampled mid-cycle, acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = GPJK_RESP_OKAY,
                      input logic [3:0] s = 4'hf);
        logic aHs, wHs, bHs;
        logic [1:0] resp;
        bHs = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // No cycle limit here; only the watchdog ends a hung transfer
        while (!bHs) begin
            @(negedge clk);
            aHs  = awvalid && awready;
            wHs  = wvalid && wready;
            bHs  = bvalid && bready;
            resp = bresp;
            @(posedge clk);
            if (aHs) awvalid <= 1'b0;
            if (wHs) wvalid <= 1'b0;
            if (bHs) bready <= 1'b0;
        end
        chk({30'h0, resp}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = GPJK_RESP_OKAY);
        logic        aHs, rHs;
        logic [31:0] data;
        logic [1:0]  resp;
        rHs = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!rHs) begin
            @(negedge clk);
            aHs  = arvalid && arready;
            rHs  = rvalid && rready;
            data = rdata;
            resp = rresp;
            @(posedge clk);
            if (aHs) arvalid <= 1'b0;
            if (rHs) rready <= 1'b0;
        end
        chk(data, ed, "read data");
        chk({30'h0, resp}, {30'h0, er}, "read response");
    endtask

    // Ends off the edge so pin outputs are compared settled
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    logic [7:0] regAddr [8] = '{8'h04, 8'h08, 8'h0c, 8'h2c, 8'h38, 8'h40, 8'h44, 8'h48};
    logic [31:0] regMask [8] = '{32'h7, 32'h7, 32'h2, 32'h6, 32'h7, 32'hff, 32'hff, 32'hff};

    initial begin
        #200000;
        bad_count++;
        test_done();
    end

    initial begin
        resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; widePinIn = 8'h00;
        timerNine = 1'b0; sysClkOut = 1'b0; alarm = 1'b0; timerSix = 1'b0; timerSeven = 1'b0;
        stopMode = 1'b0; extLevel = 3'h0; extEn = 3'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        settle();
        chk({smallPinOe, smallPullupEn, smallInBufEn, extIrqLines}, 32'h0, "reset pins");
        for (int i = 0; i < 8; i++) begin
            rd(regAddr[i], 32'h0);
            wr(regAddr[i], 32'hffffffff);
            rd(regAddr[i], regMask[i]);
            wr(regAddr[i], 32'h0);
        end
        wr(8'h04, 32'h7, GPJK_RESP_OKAY, 4'he);
        rd(8'h04, 32'h0);
        wr(8'h04, 32'h7); wr(8'h00, 32'hfffffff6); settle();
        chk(smallPinOut, 3'b110, "driven data");
        chk(smallPinOe, 3'b111, "drivers on, pin0 pulls low");
        rd(8'h00, 32'h6);
        wr(8'h00, 32'h1); settle();
        chk({smallPinOut[0], smallPinOe}, 4'b0110, "open drain released for high");
        timerNine <= 1'b1; sysClkOut <= 1'b1;
        wr(8'h00, 32'h0); wr(8'h08, 32'h6); settle();
        chk(smallPinOut, 3'b110, "timer and clock outputs");
        alarm <= 1'b1; sysClkOut <= 1'b0;
        wr(8'h08, 32'h0); wr(8'h0c, 32'h2); settle();
        chk(smallPinOut, 3'b010, "alarm output");
        wr(8'h08, 32'h2);
        settle();
        chk(smallPinOut[1], 1'b0, "clock output wins over alarm");
        extLevel <= 3'b101; extEn <= 3'b111;
        wr(8'h0c, 32'h0); wr(8'h04, 32'h0); wr(8'h38, 32'h7); wr(8'h08, 32'h1); settle();
        rd(8'h00, 32'h5);
        chk({smallInBufEn, cecInput}, 4'b1111, "input buffers and cec");
        wr(8'h2c, 32'hff); settle();
        chk(smallPullupEn, 3'b110, "no pull-up on pin0");
        timerSix <= 1'b1; widePinIn <= 8'h4a;
        wr(8'h40, 32'h30); wr(8'h48, 32'hff); settle();
        chk({wideTimerOut, wideTimerOe}, 4'b0111, "wide timer outputs");
        chk(extIrqLines, 6'b011010, "irq by input enable alone");
        chk(wideInBufEn, 8'hff, "wide input enables");
        stopMode <= 1'b1;
        wr(8'h40, 32'hc0); settle();
        chk(extIrqLines, 6'b010000, "stop needs function and input");
        wr(8'h44, 32'h1ff); settle();
        chk(widePullupEn, 8'hff, "wide pull-ups");
        wr(8'h50, 32'hff, GPJK_RESP_SLVERR);
        rd(8'h50, 32'h0, GPJK_RESP_SLVERR);
        test_done();
    end
endmodule // gpjk_port_ctrl_tb
